// File: alu_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
// operands from the sequencing top into the datapath and its combinational result back
interface alu_bus_if;
   import bitops_pkg::*;
   op_t op;
   logic [7:0] mem_in;
   logic [7:0] work_in;
   logic [2:0] bit_sel;
   logic half_carry_in;
   logic carry_in;
   logic [7:0] result;
   logic carry_out;
   modport core (output op, mem_in, work_in, bit_sel, half_carry_in, carry_in, input result, carry_out);
   modport unit (input op, mem_in, work_in, bit_sel, half_carry_in, carry_in, output result, carry_out);
endinterface : alu_bus_if
`default_nettype wire

// File: alu_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "bitops_params.svh"
module alu_unit
   import bitops_pkg::*;
(
   alu_bus_if.unit bus
);
   logic [4:0] lo_sum;
   logic [4:0] hi_sum;
   logic lo_fix;
   logic hi_fix;

   // bcd correction: low digit first, its carry feeds the high digit
   always_comb begin
      lo_fix = (bus.work_in[3:0] > `BCD_MAX_DIGIT) || bus.half_carry_in; // RULE7
      lo_sum = {1'b0, bus.work_in[3:0]} + (lo_fix ? {1'b0, `BCD_FIX} : 5'h00); // RULE7
      hi_sum = {1'b0, bus.work_in[7:4]} + {4'h0, lo_sum[4]};
      hi_fix = (hi_sum > {1'b0, `BCD_MAX_DIGIT}) || bus.carry_in; // RULE8
      if (hi_fix) begin
         hi_sum = hi_sum + {1'b0, `BCD_FIX}; // RULE8
      end
   end

   // result mux per instruction
   always_comb begin
      bus.result = bus.mem_in;
      bus.carry_out = bus.carry_in;
      unique case (bus.op)
         CLEAR_BYTE_OP: bus.result = `CLEAR_VALUE; // RULE1
         CLEAR_BIT_OP: bus.result = bus.mem_in & ~(8'h01 << bus.bit_sel); // RULE2
         INVERT_IN_PLACE_OP: bus.result = ~bus.mem_in; // RULE4
         INVERT_INTO_WORKING_OP: bus.result = ~bus.mem_in; // RULE5
         DECIMAL_ADJUST_OP: begin
            bus.result = {hi_sum[3:0], lo_sum[3:0]}; // RULE6
            bus.carry_out = hi_fix | hi_sum[4] | bus.carry_in; // RULE8
         end
         default: bus.result = bus.mem_in;
      endcase
   end
endmodule : alu_unit
`default_nettype wire

// File: bitops_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "bitops_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// RULE1 - clear-byte writes 00H to the addressed byte, flags untouched
// RULE2 - clear-bit zeroes only the selected bit, flags untouched
// RULE3 - watchdog kick restarts counter, clears timeout and power-down flags only
// RULE4 - in-place invert writes ones' complement back and updates zero flag
// RULE5 - invert-into-working loads complement into working register, updates zero flag
// RULE6 - decimal adjust turns working register into packed BCD stored in memory
// RULE7 - low nibble above 9 or half-carry set adds 6 to low nibble
// RULE8 - high nibble above 9 or carry set adds 6 and sets carry
module bitops_core
   import bitops_pkg::*;
(
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // instruction issue
   input wire logic issue,
   input wire op_t op,
   input wire logic [2:0] bit_sel,
   input wire logic [7:0] mem_rdata,
   // flag and event inputs
   input wire logic half_carry_flag,
   input wire logic carry_in,
   input wire logic zero_in,
   input wire logic set_timeout,
   input wire logic set_power_down,
   // memory write-back
   output logic mem_we,
   output logic [7:0] mem_wdata,
   // core state
   output logic [7:0] working_register,
   output logic zero_flag,
   output logic carry_flag,
   output logic timeout_flag,
   output logic power_down_flag,
   output logic [`WDOG_W-1:0] watchdog_counter
);
   alu_bus_if bus ();
   logic go;

   assign go = clk_en & issue;
   assign bus.op = op;
   assign bus.mem_in = mem_rdata;
   assign bus.work_in = working_register;
   assign bus.bit_sel = bit_sel;
   assign bus.half_carry_in = half_carry_flag;
   assign bus.carry_in = carry_in;

   alu_unit u_alu (
      .bus(bus.unit)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // memory write-back, one cycle after issue
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mem_we <= 1'b0;
         mem_wdata <= 8'h00;
      end else if (clk_en) begin
         mem_we <= 1'b0;
         if (issue && (op == CLEAR_BYTE_OP || op == CLEAR_BIT_OP || op == INVERT_IN_PLACE_OP ||
                       op == DECIMAL_ADJUST_OP)) begin
            mem_we <= 1'b1; // RULE1
            mem_wdata <= bus.result; // RULE6
         end
      end
   end

   // working register only loaded by invert-into-working; memory left as is
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         working_register <= 8'h00;
      end else if (go && op == INVERT_INTO_WORKING_OP) begin
         working_register <= bus.result; // RULE5
      end
   end

   // zero and carry flags; clear ops deliberately leave both alone
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         zero_flag <= 1'b0;
         carry_flag <= 1'b0;
      end else if (clk_en) begin
         zero_flag <= zero_in;
         carry_flag <= carry_in;
         if (issue && (op == INVERT_IN_PLACE_OP || op == INVERT_INTO_WORKING_OP)) begin
            zero_flag <= (bus.result == 8'h00); // RULE4
         end
         if (issue && op == DECIMAL_ADJUST_OP) begin
            carry_flag <= bus.carry_out; // RULE8
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog flags: an event in the kick cycle wins so it is not lost
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         timeout_flag <= 1'b0;
         power_down_flag <= 1'b0;
      end else if (clk_en) begin
         if (set_timeout) begin
            timeout_flag <= 1'b1;
         end else if (issue && op == KICK_WATCHDOG_OP) begin
            timeout_flag <= 1'b0; // RULE3
         end
         if (set_power_down) begin
            power_down_flag <= 1'b1;
         end else if (issue && op == KICK_WATCHDOG_OP) begin
            power_down_flag <= 1'b0; // RULE3
         end
      end
   end

   // free count; kick restarts it
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         watchdog_counter <= `WDOG_RESTART;
      end else if (clk_en) begin
         if (issue && op == KICK_WATCHDOG_OP) begin
            watchdog_counter <= `WDOG_RESTART; // RULE3
         end else begin
            watchdog_counter <= watchdog_counter + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_kick;
      clk_en && issue && op == KICK_WATCHDOG_OP && !set_timeout && !set_power_down;
   endsequence
   sequence s_flags_low;
      !timeout_flag && !power_down_flag && watchdog_counter == `WDOG_RESTART;
   endsequence

   property p_clear_byte;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && issue && op == CLEAR_BYTE_OP |=> mem_we && mem_wdata == 8'h00;
   endproperty
   a_clear_byte: assert property (p_clear_byte) else $error("clear byte not zero"); // RULE1

   property p_clear_bit;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && issue && op == CLEAR_BIT_OP |=>
         mem_we && !mem_wdata[$past(bit_sel)] && (mem_wdata | (8'h01 << $past(bit_sel))) ==
         ($past(mem_rdata) | (8'h01 << $past(bit_sel)));
   endproperty
   a_clear_bit: assert property (p_clear_bit) else $error("clear bit wrong"); // RULE2

   property p_kick;
      @(posedge core_clk) disable iff (!rst_n)
      s_kick |=> s_flags_low;
   endproperty
   a_kick: assert property (p_kick) else $error("kick did not clear"); // RULE3

   property p_invert;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && issue && op == INVERT_IN_PLACE_OP |=>
         mem_we && mem_wdata == ~$past(mem_rdata) && zero_flag == ($past(mem_rdata) == 8'hff);
   endproperty
   a_invert: assert property (p_invert) else $error("invert in place wrong"); // RULE4

   property p_invert_work;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && issue && op == INVERT_INTO_WORKING_OP |=>
         !mem_we && working_register == ~$past(mem_rdata) && zero_flag == (working_register == 8'h00);
   endproperty
   a_invert_work: assert property (p_invert_work) else $error("invert into working wrong"); // RULE5

   property p_daa_write;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && issue && op == DECIMAL_ADJUST_OP |=> mem_we && mem_wdata[3:0] <= 4'h9;
   endproperty
   a_daa_write: assert property (p_daa_write) else $error("adjust result not bcd"); // RULE6

   property p_daa_low;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && issue && op == DECIMAL_ADJUST_OP && working_register[3:0] <= 4'h9 && !half_carry_flag
         |=> mem_wdata[3:0] == $past(working_register[3:0]);
   endproperty
   a_daa_low: assert property (p_daa_low) else $error("low nibble changed"); // RULE7

   property p_daa_carry;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && issue && op == DECIMAL_ADJUST_OP && working_register[7:4] > 4'h9 |=> carry_flag;
   endproperty
   a_daa_carry: assert property (p_daa_carry) else $error("adjust carry not set"); // RULE8

   // clear ops must not disturb the flags or the working register
   sequence s_clear_any;
      clk_en && issue && (op == CLEAR_BYTE_OP || op == CLEAR_BIT_OP);
   endsequence
   property p_clear_flags;
      @(posedge core_clk) disable iff (!rst_n)
      s_clear_any |=> zero_flag == $past(zero_in) && carry_flag == $past(carry_in) &&
         working_register == $past(working_register);
   endproperty
   a_clear_flags: assert property (p_clear_flags) else $error("clear op touched flags"); // RULE1 RULE2

   // a set half-carry alone forces the low digit fix
   property p_daa_half;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && issue && op == DECIMAL_ADJUST_OP && working_register[3:0] <= 4'h9 && half_carry_flag
         |=> mem_wdata[3:0] == $past(working_register[3:0]) + 4'h6;
   endproperty
   a_daa_half: assert property (p_daa_half) else $error("half carry fix missing"); // RULE7

   // a low enable holds every piece of state, whatever else arrives
   property p_freeze;
      @(posedge core_clk) disable iff (!rst_n)
      !clk_en |=> $stable(mem_we) && $stable(mem_wdata) && $stable(working_register) && $stable(zero_flag) &&
         $stable(carry_flag) && $stable(timeout_flag) && $stable(power_down_flag) && $stable(watchdog_counter);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with enable low");

   // events beat a kick in the same cycle so a timeout is never lost
   property p_timeout_wins;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && set_timeout |=> timeout_flag;
   endproperty
   a_timeout_wins: assert property (p_timeout_wins) else $error("timeout event lost"); // RULE3

   property p_power_down_wins;
      @(posedge core_clk) disable iff (!rst_n)
      clk_en && set_power_down |=> power_down_flag;
   endproperty
   a_power_down_wins: assert property (p_power_down_wins) else $error("power down event lost"); // RULE3
endmodule : bitops_core
`default_nettype wire

// File: bitops_params.svh
`ifndef BITOPS_PARAMS_SVH
`define BITOPS_PARAMS_SVH
// data width and bcd constants
`define DATA_W 8
`define CLEAR_VALUE 8'h00
`define BCD_MAX_DIGIT 4'h9
`define BCD_FIX 4'h6
// watchdog counter width and restart value
`define WDOG_W 16
`define WDOG_RESTART 16'h0000
`endif

// File: bitops_pkg.sv
package bitops_pkg;
   // instruction selection presented by the core
   typedef enum logic [2:0] {
      NOP_OP = 3'b000,
      CLEAR_BYTE_OP = 3'b001,
      CLEAR_BIT_OP = 3'b010,
      KICK_WATCHDOG_OP = 3'b011,
      INVERT_IN_PLACE_OP = 3'b100,
      INVERT_INTO_WORKING_OP = 3'b101,
      DECIMAL_ADJUST_OP = 3'b110
   } op_t;
endpackage : bitops_pkg

// File: mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_model (
   // clock
   input wire logic core_clk,
   // preload from the bench
   input wire logic ld,
   input wire logic [7:0] ld_val,
   // write-back from the core
   input wire logic mem_we,
   input wire logic [7:0] mem_wdata,
   // addressed byte
   output logic [7:0] rdata
);
   // one byte stands for the addressed location; a preload wins so a test can seed it
   always_ff @(posedge core_clk) begin
      if (ld) begin
         rdata <= ld_val;
      end else if (mem_we) begin
         rdata <= mem_wdata;
      end
   end
endmodule : mem_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import bitops_pkg::*;
   logic core_clk, rst_n, clk_en, issue, half_carry_flag, carry_in, zero_in, set_timeout, set_power_down;
   logic ld, mem_we, zero_flag, carry_flag, timeout_flag, power_down_flag;
   op_t op;
   logic [2:0] bit_sel;
   logic [7:0] ld_val, mem_rdata, mem_wdata, working_register;
   logic [15:0] watchdog_counter;
   int mismatches = 0;
   int comparisons = 0;
   ////////////////////////////////////////////////////////////////////////////////
   bitops_core i_dut (.core_clk, .rst_n, .clk_en, .issue, .op, .bit_sel, .mem_rdata, .half_carry_flag,
      .carry_in, .zero_in, .set_timeout, .set_power_down, .mem_we, .mem_wdata, .working_register,
      .zero_flag, .carry_flag, .timeout_flag, .power_down_flag, .watchdog_counter);
   mem_model i_mem (.core_clk, .ld, .ld_val, .mem_we, .mem_wdata, .rdata(mem_rdata));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk8
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask : chk1
   // seed the byte, issue one instruction, return once its result is visible
   task automatic run(input op_t o, input logic [7:0] m, input logic [2:0] b, input logic hc, input logic c,
                      input logic z);
      @(posedge core_clk);
      ld <= 1'b1;
      ld_val <= m;
      @(posedge core_clk);
      ld <= 1'b0;
      issue <= 1'b1;
      op <= o;
      bit_sel <= b;
      half_carry_flag <= hc;
      carry_in <= c;
      zero_in <= z;
      @(posedge core_clk);
      issue <= 1'b0;
      #1;
   endtask : run
   task automatic clear_test;
      run(CLEAR_BYTE_OP, 8'ha5, 3'h0, 1'b0, 1'b1, 1'b1);
      chk1(mem_we, 1'b1);
      chk8(mem_wdata, 8'h00);
      chk1(zero_flag, 1'b1);
      chk1(carry_flag, 1'b1);
      for (int i = 0; i < 8; i++) begin
         run(CLEAR_BIT_OP, 8'hff, 3'(i), 1'b0, 1'b0, 1'b1);
         chk8(mem_wdata, ~(8'h01 << i));
         chk1(zero_flag, 1'b1);
      end
   endtask : clear_test
   task automatic kick_test;
      @(posedge core_clk);
      set_timeout <= 1'b1;
      set_power_down <= 1'b1;
      @(posedge core_clk);
      set_timeout <= 1'b0;
      set_power_down <= 1'b0;
      #1;
      chk1(timeout_flag, 1'b1);
      chk1(power_down_flag, 1'b1);
      run(KICK_WATCHDOG_OP, 8'h5a, 3'h0, 1'b0, 1'b1, 1'b1);
      chk1(timeout_flag, 1'b0);
      chk1(power_down_flag, 1'b0);
      chk1(watchdog_counter === 16'h0000, 1'b1);
      chk1(mem_we, 1'b0);
      chk1(carry_flag, 1'b1);
      // kick and timeout event in one cycle: the event wins, power-down stays clear
      @(posedge core_clk);
      issue <= 1'b1;
      set_timeout <= 1'b1;
      @(posedge core_clk);
      issue <= 1'b0;
      set_timeout <= 1'b0;
      #1;
      chk1(timeout_flag, 1'b1);
      chk1(power_down_flag, 1'b0);
   endtask : kick_test
   // enable low: an issued kick, a flag event and the free count must all hold
   task automatic freeze_test;
      logic [15:0] wd;
      run(INVERT_INTO_WORKING_OP, 8'h00, 3'h0, 1'b0, 1'b0, 1'b0);
      @(posedge core_clk);
      clk_en <= 1'b0;
      issue <= 1'b1;
      op <= KICK_WATCHDOG_OP;
      zero_in <= 1'b1;
      set_power_down <= 1'b1;
      #1;
      wd = watchdog_counter;
      repeat (3) @(posedge core_clk);
      #1;
      chk1(mem_we, 1'b0);
      chk1(zero_flag, 1'b0);
      chk1(timeout_flag, 1'b1);
      chk1(power_down_flag, 1'b0);
      chk8(working_register, 8'hff);
      chk1(watchdog_counter === wd, 1'b1);
      @(posedge core_clk);
      clk_en <= 1'b1;
      issue <= 1'b0;
      set_power_down <= 1'b0;
      @(posedge core_clk);
      #1;
      chk1(watchdog_counter === wd + 16'h0001, 1'b1);
   endtask : freeze_test
   task automatic invert_test;
      run(INVERT_IN_PLACE_OP, 8'h0f, 3'h0, 1'b0, 1'b0, 1'b1);
      chk8(mem_wdata, 8'hf0);
      chk1(zero_flag, 1'b0);
      @(posedge core_clk);
      #1;
      chk8(mem_rdata, 8'hf0);
      run(INVERT_IN_PLACE_OP, 8'hff, 3'h0, 1'b0, 1'b0, 1'b0);
      chk1(zero_flag, 1'b1);
      run(INVERT_INTO_WORKING_OP, 8'h3c, 3'h0, 1'b0, 1'b0, 1'b1);
      chk8(working_register, 8'hc3);
      chk1(mem_we, 1'b0);
      chk1(zero_flag, 1'b0);
      chk8(mem_rdata, 8'h3c);
      run(INVERT_INTO_WORKING_OP, 8'hff, 3'h0, 1'b0, 1'b0, 1'b0);
      chk1(zero_flag, 1'b1);
   endtask : invert_test
   // working value loaded through the invert op, then adjusted; covers both nibble fixes
   task automatic bcd_test;
      logic [7:0] w [6] = '{8'h0a, 8'h12, 8'h12, 8'ha0, 8'h19, 8'h9a};
      logic [7:0] e [6] = '{8'h10, 8'h18, 8'h12, 8'h00, 8'h79, 8'h00};
      logic [5:0] hv = 6'h02;
      logic [5:0] cv = 6'h10;
      logic [5:0] ce = 6'h38;
      for (int i = 0; i < 6; i++) begin
         run(INVERT_INTO_WORKING_OP, ~w[i], 3'h0, 1'b0, 1'b0, 1'b0);
         run(DECIMAL_ADJUST_OP, 8'h00, 3'h0, hv[i], cv[i], 1'b0);
         chk1(mem_we, 1'b1);
         chk8(mem_wdata, e[i]);
         chk1(carry_flag, ce[i]);
      end
   endtask : bcd_test
   task automatic final_report;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////////////////
   // 50 ns period
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // the whole sequence needs some 100 cycles; 2000 leaves room
   initial begin
      #100_000;
      mismatches++;
      final_report();
   end
   initial begin
      {rst_n, issue, half_carry_flag, carry_in, zero_in, set_timeout, set_power_down, ld} = '0;
      clk_en = 1'b1;
      op = NOP_OP;
      bit_sel = 3'h0;
      ld_val = 8'h00;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      clear_test();
      kick_test();
      invert_test();
      bcd_test();
      freeze_test();
      final_report();
   end
endmodule : testbench
`default_nettype wire
